//--- rsl_pkg.sv
// Constants, register map and types of the serial slave link control block.
package rsl_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned CHAR_BITS = 10;
    localparam int unsigned BAUD_RATE [8] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};
    // Index of the reply delay select: 0 answers at once.
    localparam int unsigned REPLY_CHARS [6] = '{0, 10, 20, 50, 100, 200};
    localparam logic [2:0] REPLY_SEL_MAX = 3'h5;
    localparam logic [7:0] STATION_MAX = 8'hC7;
    localparam logic [7:0] STATION_ANY = 8'hFF;
    localparam logic [6:0] GAP_LIMIT_MAX = 7'h63;
    localparam logic [7:0] LINK_REG_AO = 8'h04;
    localparam logic [7:0] LINK_REG_RELAY = 8'h05;
    // Bus register byte offsets.
    localparam logic [7:0] OFS_STATION = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_GAP = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_MASK = 8'h10;
    localparam logic [7:0] OFS_STATE = 8'h14;
    // Control register fields.
    localparam int CTRL_BAUD_LSB = 0;
    localparam int CTRL_WEN_BIT = 3;
    localparam int CTRL_REPLY_LSB = 4;
    localparam int CTRL_AO_REMOTE_BIT = 7;
    localparam int CTRL_FAULT_LSB = 8;
    // Status and mask bits.
    localparam int ST_FRAME = 0;
    localparam int ST_REFUSED = 1;
    localparam int ST_TIMEOUT = 2;
    localparam int ST_REPLY = 3;
    localparam int ST_W = 4;
    // Reset values.
    localparam logic [7:0] RST_STATION = 8'h01;
    localparam logic [2:0] RST_BAUD = 3'h3;
    localparam logic [6:0] RST_GAP = 7'h00;
    typedef enum logic [1:0] {FAULT_HOLD, FAULT_HIGH, FAULT_LOW, FAULT_ZERO} rsl_fault_type;
endpackage : rsl_pkg

//--- rsl_gap_watchdog.sv
// Supervision of the gap between received frames, in whole seconds.
`timescale 1ns/1ns
module rsl_gap_watchdog #(
    parameter int SEC_CYCLES = 50_000_000
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic restart,
    input wire logic [6:0] limit,
    output logic timeout
);
    logic [31:0] cyc_r, cyc_nxt;
    logic [6:0] sec_r, sec_nxt;
    logic to_r, to_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        cyc_nxt = cyc_r;
        sec_nxt = sec_r;
        to_nxt = to_r;
        if (restart || limit == 7'h00)
        begin
            cyc_nxt = '0;
            sec_nxt = '0;
            to_nxt = 1'b0;
        end
        else if (!to_r)
        begin
            if (cyc_r == 32'(SEC_CYCLES - 1))
            begin
                cyc_nxt = '0;
                sec_nxt = sec_r + 7'h01;
                // The alert is raised as soon as the full limit has elapsed.
                if (sec_r + 7'h01 >= limit)
                begin
                    to_nxt = 1'b1;
                end
            end
            else
            begin
                cyc_nxt = cyc_r + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cyc_r <= '0;
            sec_r <= '0;
            to_r <= 1'b0;
        end
        else
        begin
            cyc_r <= cyc_nxt;
            sec_r <= sec_nxt;
            to_r <= to_nxt;
        end
    end

    assign timeout = to_r;
endmodule : rsl_gap_watchdog

//--- rsl_reply_delay.sv
// Reply delay counted in character times after the last request character.
`timescale 1ns/1ns
module rsl_reply_delay (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic start,
    input wire logic [7:0] n_chars,
    input wire logic [23:0] char_cycles,
    output logic done
);
    typedef enum logic {DLY_IDLE, DLY_WAIT} rsl_dly_type;
    rsl_dly_type st_r, st_nxt;
    logic [23:0] cyc_r, cyc_nxt;
    logic [7:0] chr_r, chr_nxt;
    logic done_r, done_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_nxt = st_r;
        cyc_nxt = cyc_r;
        chr_nxt = chr_r;
        done_nxt = 1'b0;
        // A new request restarts the wait; the older reply is dropped.
        if (start)
        begin
            cyc_nxt = '0;
            chr_nxt = '0;
            if (n_chars == 8'h00)
            begin
                done_nxt = 1'b1;
                st_nxt = DLY_IDLE;
            end
            else
            begin
                st_nxt = DLY_WAIT;
            end
        end
        else
        begin
            case (st_r)
                DLY_IDLE:
                begin
                    st_nxt = DLY_IDLE;
                end
                DLY_WAIT:
                begin
                    if (cyc_r == char_cycles - 24'h00_0001)
                    begin
                        cyc_nxt = '0;
                        chr_nxt = chr_r + 8'h01;
                        if (chr_r + 8'h01 == n_chars)
                        begin
                            done_nxt = 1'b1;
                            st_nxt = DLY_IDLE;
                        end
                    end
                    else
                    begin
                        cyc_nxt = cyc_r + 24'h00_0001;
                    end
                end
                default:
                begin
                    st_nxt = DLY_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_r <= DLY_IDLE;
            cyc_r <= '0;
            chr_r <= '0;
            done_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            cyc_r <= cyc_nxt;
            chr_r <= chr_nxt;
            done_r <= done_nxt;
        end
    end

    assign done = done_r;
endmodule : rsl_reply_delay

//--- rsl_link_ctrl.sv
// Serial slave link control: station match, write gating, supervision, reply delay.
`timescale 1ns/1ns
module rsl_link_ctrl #(
    parameter int CLK_HZ = rsl_pkg::CLK_HZ,
    parameter int SEC_CYCLES = rsl_pkg::CLK_HZ,
    parameter logic [15:0] FAULT_HI_CODE = 16'hFFFF,
    parameter logic [15:0] FAULT_LO_CODE = 16'h0100
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic frame_done,
    input wire logic [7:0] frame_addr,
    input wire logic [7:0] frame_reg,
    input wire logic frame_write,
    input wire logic [15:0] frame_data,
    input wire logic [15:0] ao_normal_value,
    input wire logic critical_in,
    output logic reply_go,
    output logic reply_exception,
    output logic cfg_wr_strobe,
    output logic [7:0] cfg_wr_reg,
    output logic [15:0] cfg_wr_data,
    output logic [23:0] bit_cycles,
    output logic [15:0] ao_value,
    output logic [3:0] relay_out,
    output logic alert,
    output logic irq
);
    if (CLK_HZ < 2 * 115200 || CLK_HZ / 1200 * 10 > 16_777_215 || SEC_CYCLES < 2)
    begin : g_check
        $error("rsl_link_ctrl: clock or second count out of range for the line rates");
    end

    logic [23:0] bit_tab [8];
    for (genvar i = 0; i < 8; i++)
    begin : g_baud
        assign bit_tab[i] = 24'(CLK_HZ / rsl_pkg::BAUD_RATE[i]);
    end

    logic [7:0] station_r, station_nxt;
    logic [9:0] ctrl_r, ctrl_nxt;
    logic [6:0] gap_r, gap_nxt;
    logic [3:0] status_r, status_nxt, mask_r, mask_nxt;
    logic wr_pend_r, wr_pend_nxt;
    logic [7:0] wr_ofs_r, wr_ofs_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic exc_r, exc_nxt;
    logic [15:0] remote_ao_r, remote_ao_nxt, ao_r, ao_nxt;
    logic [3:0] remote_rel_r, remote_rel_nxt, relay_r, relay_nxt;
    logic reply_r, reply_nxt, rexc_r, rexc_nxt, cfg_r, cfg_nxt;
    logic [7:0] cfg_reg_r, cfg_reg_nxt;
    logic [15:0] cfg_data_r, cfg_data_nxt;
    logic [23:0] bitc_r, bitc_nxt;
    logic alert_r, irq_r, irq_nxt, timeout, dly_done;
    logic ap_valid, match, allowed, refused;
    logic [7:0] n_chars;
    logic [23:0] char_cycles;
    logic [3:0] ev;
    rsl_pkg::rsl_fault_type fault_sel;
    logic [15:0] fault_val;
    logic [2:0] reply_sel;

    assign reply_sel = ctrl_r[rsl_pkg::CTRL_REPLY_LSB +: 3];
    assign fault_sel = rsl_pkg::rsl_fault_type'(ctrl_r[rsl_pkg::CTRL_FAULT_LSB +: 2]);
    assign char_cycles = 24'(bitc_r * rsl_pkg::CHAR_BITS);
    // Slow converters at the three fastest rates want 10, 20 and 50 characters.
    assign n_chars = 8'(rsl_pkg::REPLY_CHARS[reply_sel]);

    ////////////////////////////////////////////////////////////////////////////////
    // Link request decode.
    always_comb
    begin
        match = frame_done && ((station_r != 8'h00 && frame_addr == station_r)
            || (station_r == 8'h00 && frame_addr == rsl_pkg::STATION_ANY));
        allowed = !frame_write || ctrl_r[rsl_pkg::CTRL_WEN_BIT]
            || frame_reg == rsl_pkg::LINK_REG_AO || frame_reg == rsl_pkg::LINK_REG_RELAY;
        refused = match && !allowed;
    end

    rsl_reply_delay u_dly (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(match),
        .n_chars(n_chars),
        .char_cycles(char_cycles),
        .done(dly_done)
    );

    rsl_gap_watchdog #(.SEC_CYCLES(SEC_CYCLES)) u_wdg (
        .hclk(hclk),
        .hresetn(hresetn),
        .restart(frame_done),
        .limit(gap_r),
        .timeout(timeout)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Bus registers, link writes and outputs.
    always_comb
    begin
        ap_valid = hsel && htrans[1] && hready;
        wr_pend_nxt = ap_valid && hwrite;
        wr_ofs_nxt = ap_valid ? haddr[7:0] : wr_ofs_r;
        station_nxt = station_r;
        ctrl_nxt = ctrl_r;
        gap_nxt = gap_r;
        mask_nxt = mask_r;
        ev = '0;
        ev[rsl_pkg::ST_FRAME] = match;
        ev[rsl_pkg::ST_REFUSED] = refused;
        ev[rsl_pkg::ST_TIMEOUT] = timeout && !alert_r;
        ev[rsl_pkg::ST_REPLY] = dly_done;
        status_nxt = status_r;
        if (wr_pend_r)
        begin
            case (wr_ofs_r)
                rsl_pkg::OFS_STATION:
                begin
                    if (hwdata[7:0] <= rsl_pkg::STATION_MAX)
                    begin
                        station_nxt = hwdata[7:0];
                    end
                end
                rsl_pkg::OFS_CTRL:
                begin
                    if (hwdata[rsl_pkg::CTRL_REPLY_LSB +: 3] <= rsl_pkg::REPLY_SEL_MAX)
                    begin
                        ctrl_nxt = hwdata[9:0];
                    end
                end
                rsl_pkg::OFS_GAP:
                begin
                    if (hwdata[6:0] <= rsl_pkg::GAP_LIMIT_MAX)
                    begin
                        gap_nxt = hwdata[6:0];
                    end
                end
                rsl_pkg::OFS_STATUS:
                begin
                    status_nxt = status_r & ~hwdata[3:0];
                end
                rsl_pkg::OFS_MASK:
                begin
                    mask_nxt = hwdata[3:0];
                end
                default:
                begin
                    station_nxt = station_r;
                end
            endcase
        end
        // Setting after clearing keeps an event that lands on the clear.
        status_nxt = status_nxt | ev;
        irq_nxt = |(status_nxt & mask_nxt);
        hrdata_nxt = hrdata_r;
        if (ap_valid && !hwrite)
        begin
            case (haddr[7:0])
                rsl_pkg::OFS_STATION: hrdata_nxt = {24'h00_0000, station_r};
                rsl_pkg::OFS_CTRL: hrdata_nxt = {22'h00_0000, ctrl_r};
                rsl_pkg::OFS_GAP: hrdata_nxt = {25'h000_0000, gap_r};
                rsl_pkg::OFS_STATUS: hrdata_nxt = {28'h000_0000, status_r};
                rsl_pkg::OFS_MASK: hrdata_nxt = {28'h000_0000, mask_r};
                rsl_pkg::OFS_STATE: hrdata_nxt = {ao_r, 8'h00, relay_r, 3'h0, alert_r};
                default: hrdata_nxt = 32'h0000_0000;
            endcase
        end
        remote_ao_nxt = remote_ao_r;
        remote_rel_nxt = remote_rel_r;
        cfg_nxt = 1'b0;
        cfg_reg_nxt = cfg_reg_r;
        cfg_data_nxt = cfg_data_r;
        if (match && frame_write && allowed)
        begin
            if (frame_reg == rsl_pkg::LINK_REG_AO)
            begin
                remote_ao_nxt = frame_data;
            end
            else if (frame_reg == rsl_pkg::LINK_REG_RELAY)
            begin
                remote_rel_nxt = frame_data[3:0];
            end
            else
            begin
                cfg_nxt = 1'b1;
                cfg_reg_nxt = frame_reg;
                cfg_data_nxt = frame_data;
            end
        end
        exc_nxt = match ? refused : exc_r;
        reply_nxt = dly_done;
        rexc_nxt = dly_done && exc_r;
        bitc_nxt = bit_tab[ctrl_r[rsl_pkg::CTRL_BAUD_LSB +: 3]];
        case (fault_sel)
            rsl_pkg::FAULT_HOLD: fault_val = ao_r;
            rsl_pkg::FAULT_HIGH: fault_val = FAULT_HI_CODE;
            rsl_pkg::FAULT_LOW: fault_val = FAULT_LO_CODE;
            default: fault_val = 16'h0000;
        endcase
        if (ctrl_r[rsl_pkg::CTRL_AO_REMOTE_BIT])
        begin
            ao_nxt = (timeout || critical_in) ? fault_val : remote_ao_r;
        end
        else
        begin
            ao_nxt = critical_in ? fault_val : ao_normal_value;
        end
        // Alert state of a remote relay is de-energised.
        relay_nxt = timeout ? 4'h0 : remote_rel_r;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            station_r <= rsl_pkg::RST_STATION;
            ctrl_r <= {7'h00, rsl_pkg::RST_BAUD};
            gap_r <= rsl_pkg::RST_GAP;
            status_r <= '0;
            mask_r <= '0;
            wr_pend_r <= 1'b0;
            wr_ofs_r <= '0;
            hrdata_r <= '0;
            exc_r <= 1'b0;
            remote_ao_r <= '0;
            remote_rel_r <= '0;
            ao_r <= '0;
            relay_r <= '0;
            reply_r <= 1'b0;
            rexc_r <= 1'b0;
            cfg_r <= 1'b0;
            cfg_reg_r <= '0;
            cfg_data_r <= '0;
            bitc_r <= '0;
            alert_r <= 1'b0;
            irq_r <= 1'b0;
        end
        else
        begin
            station_r <= station_nxt;
            ctrl_r <= ctrl_nxt;
            gap_r <= gap_nxt;
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            wr_pend_r <= wr_pend_nxt;
            wr_ofs_r <= wr_ofs_nxt;
            hrdata_r <= hrdata_nxt;
            exc_r <= exc_nxt;
            remote_ao_r <= remote_ao_nxt;
            remote_rel_r <= remote_rel_nxt;
            ao_r <= ao_nxt;
            relay_r <= relay_nxt;
            reply_r <= reply_nxt;
            rexc_r <= rexc_nxt;
            cfg_r <= cfg_nxt;
            cfg_reg_r <= cfg_reg_nxt;
            cfg_data_r <= cfg_data_nxt;
            bitc_r <= bitc_nxt;
            alert_r <= timeout;
            irq_r <= irq_nxt;
        end
    end

    // The slave never stretches a transfer, so ready and OKAY are fixed.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;
    assign reply_go = reply_r;
    assign reply_exception = rexc_r;
    assign cfg_wr_strobe = cfg_r;
    assign cfg_wr_reg = cfg_reg_r;
    assign cfg_wr_data = cfg_data_r;
    assign bit_cycles = bitc_r;
    assign ao_value = ao_r;
    assign relay_out = relay_r;
    assign alert = alert_r;
    assign irq = irq_r;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    station_range_a: assert property (station_r <= rsl_pkg::STATION_MAX)
        else $error("station address above range");
    any_match_a: assert property (frame_done && station_r == 8'h00 && frame_addr == 8'hFF
        |=> status_r[rsl_pkg::ST_FRAME])
        else $error("substitute address not accepted");
    baud_table_a: assert property (bitc_r != 24'h00_0000
        |-> bitc_r == bit_tab[$past(ctrl_r[2:0])])
        else $error("bit time does not follow rate select");
    refused_write_a: assert property (refused |=> !cfg_wr_strobe && status_r[rsl_pkg::ST_REFUSED])
        else $error("refused write reached configuration");
    always_reg_a: assert property (match && frame_write && frame_reg == 8'h04
        |=> remote_ao_r == $past(frame_data))
        else $error("remote output register write lost");
    alert_relay_a: assert property (alert_r |-> relay_out == 4'h0)
        else $error("relay not in alert state");
    gap_off_a: assert property (gap_r == 7'h00 |-> ##2 !alert_r)
        else $error("alert with supervision off");
    zero_delay_a: assert property (match && n_chars == 8'h00 |-> ##2 reply_go)
        else $error("immediate reply not given");
    frame_release_a: assert property (frame_done |-> ##2 !alert_r)
        else $error("frame did not restart supervision");
    remote_follow_a: assert property (ctrl_r[7] && !alert_r && !timeout && !critical_in
        ##1 ctrl_r[7] |-> ao_value == $past(remote_ao_r))
        else $error("remote output not followed");
    crit_clear_a: assert property (!ctrl_r[7] && !critical_in |=> ao_value == $past(ao_normal_value))
        else $error("normal value not restored");

    reply_cov: cover property (match ##[1:1000] reply_go);
    refuse_cov: cover property (refused ##2 reply_exception);
    alert_cov: cover property (alert_r ##1 frame_done ##2 !alert_r);
endmodule : rsl_link_ctrl

//--- rsl_master_model.sv
// Behavioural remote bus master that hands complete request frames to the block.
`timescale 1ns/1ns
module rsl_master_model (
    input wire logic hclk,
    output logic frame_done,
    output logic [7:0] frame_addr,
    output logic [7:0] frame_reg,
    output logic frame_write,
    output logic [15:0] frame_data
);
    initial
    begin
        frame_done = 1'b0;
        frame_addr = 8'h00;
        frame_reg = 8'h00;
        frame_write = 1'b0;
        frame_data = 16'h0000;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // The frame is handed over whole in a single strobe cycle, after gap clock cycles.
    // Fields are inverted once the strobe drops so stale values cannot pass for valid ones.
    task automatic send(input logic [7:0] a, input logic [7:0] r, input logic w,
        input logic [15:0] d, input int gap);
        repeat (gap) @(posedge hclk);
        frame_done <= 1'b1;
        frame_addr <= a;
        frame_reg <= r;
        frame_write <= w;
        frame_data <= d;
        @(posedge hclk);
        frame_done <= 1'b0;
        frame_addr <= ~a;
        frame_reg <= ~r;
        frame_write <= ~w;
        frame_data <= ~d;
    endtask : send
endmodule : rsl_master_model

//--- rsl_link_ctrl_test.sv
// Self-checking bench for the serial slave link control block.
`timescale 1ns/1ns
module rsl_link_ctrl_test;
    // A slow system clock keeps character times short enough for a quick run.
    localparam int HZ = 230_400;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic critical_in = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [15:0] ao_normal_value = 16'h1234;
    logic hreadyout, hresp, reply_go, reply_exception, cfg_wr_strobe, alert, irq, st;
    logic frame_done, frame_write;
    logic [7:0] frame_addr, frame_reg, cfg_wr_reg;
    logic [15:0] frame_data, cfg_wr_data, ao_value;
    logic [31:0] hrdata;
    logic [23:0] bit_cycles;
    logic [3:0] relay_out;
    int fail_count = 0;
    int cmp_count = 0;
    rsl_link_ctrl #(.CLK_HZ(HZ), .SEC_CYCLES(20)) dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .frame_done, .frame_addr,
        .frame_reg, .frame_write, .frame_data, .ao_normal_value, .critical_in, .reply_go,
        .reply_exception, .cfg_wr_strobe, .cfg_wr_reg, .cfg_wr_data, .bit_cycles,
        .ao_value, .relay_out, .alert, .irq);
    rsl_master_model m (.hclk, .frame_done, .frame_addr, .frame_reg, .frame_write, .frame_data);
    always #10 hclk = ~hclk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask : cyc
    task automatic wait_rdy;
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1)
        begin
            chk(32'h0000_0000, 32'h0000_0001);
            end_of_test();
        end
    endtask : wait_rdy
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
        output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h00_0000, a};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {16'h0000, d};
        wait_rdy();
        q = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 16'h0000, q);
        chk(q, e);
    endtask : rd
    // Sends one frame and counts edges until the answer; ek of zero means no answer.
    task automatic frame(input logic [7:0] a, input logic [7:0] r, input logic w,
        input logic [15:0] d, input int ek, input logic ex, output logic s);
        int k;
        k = 0;
        s = 1'b0;
        m.send(a, r, w, d, 0);
        do
        begin
            @(posedge hclk);
            k++;
            s = s | cfg_wr_strobe;
        end
        while (reply_go !== 1'b1 && k < ek + 6);
        chk(reply_go === 1'b1 ? k : 0, ek);
        chk(reply_exception, ex);
    endtask : frame
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(rsl_pkg::OFS_STATION, 32'h0000_0001);
        rd(rsl_pkg::OFS_CTRL, 32'h0000_0003);
        rd(rsl_pkg::OFS_GAP, 32'h0000_0000);
        rd(rsl_pkg::OFS_STATUS, 32'h0000_0000);
        rd(rsl_pkg::OFS_MASK, 32'h0000_0000);
        rd(8'h18, 32'h0000_0000);
        chk(bit_cycles, HZ / 9600);
        chk({hresp, hreadyout}, 32'h0000_0001);
    endtask : t_reset
    task automatic t_rates;
        for (int i = 0; i < 8; i++)
        begin
            wr(rsl_pkg::OFS_CTRL, 16'(i));
            cyc(2);
            chk(bit_cycles, HZ / rsl_pkg::BAUD_RATE[i]);
        end
    endtask : t_rates
    task automatic t_station;
        wr(rsl_pkg::OFS_STATION, 16'h00C8);
        rd(rsl_pkg::OFS_STATION, 32'h0000_0001);
        wr(rsl_pkg::OFS_STATION, 16'h00C7);
        frame(8'hC7, 8'h30, 1'b0, 16'h0000, 2, 1'b0, st);
        frame(8'h05, 8'h30, 1'b0, 16'h0000, 0, 1'b0, st);
        wr(rsl_pkg::OFS_STATION, 16'h0000);
        frame(8'hFF, 8'h30, 1'b0, 16'h0000, 2, 1'b0, st);
        frame(8'h00, 8'h30, 1'b0, 16'h0000, 0, 1'b0, st);
        wr(rsl_pkg::OFS_STATION, 16'h0001);
    endtask : t_station
    task automatic t_gate;
        wr(rsl_pkg::OFS_CTRL, 16'h0007);
        wr(rsl_pkg::OFS_MASK, 16'h0002);
        frame(8'h01, 8'h20, 1'b1, 16'h5555, 2, 1'b1, st);
        chk(st, 1'b0);
        chk(irq, 1'b1);
        wr(rsl_pkg::OFS_STATUS, 16'h000F);
        cyc(2);
        chk(irq, 1'b0);
        frame(8'h01, 8'h05, 1'b1, 16'h000A, 2, 1'b0, st);
        chk(relay_out, 4'hA);
        wr(rsl_pkg::OFS_CTRL, 16'h018F);
        frame(8'h01, 8'h20, 1'b1, 16'h1357, 2, 1'b0, st);
        chk({st, cfg_wr_reg, cfg_wr_data}, {1'b1, 8'h20, 16'h1357});
        frame(8'h01, 8'h04, 1'b1, 16'h0ABC, 2, 1'b0, st);
        chk(ao_value, 16'h0ABC);
    endtask : t_gate
    // Two-second limit with twenty cycles to the second: forty cycles of silence trip it.
    task automatic t_watch;
        wr(rsl_pkg::OFS_GAP, 16'h0002);
        wr(rsl_pkg::OFS_GAP, 16'h0064);
        rd(rsl_pkg::OFS_GAP, 32'h0000_0002);
        frame(8'h01, 8'h05, 1'b1, 16'h000F, 2, 1'b0, st);
        cyc(30);
        m.send(8'h09, 8'h30, 1'b0, 16'h0000, 0);
        cyc(30);
        chk(alert, 1'b0);
        cyc(15);
        chk({alert, relay_out, ao_value}, {1'b1, 4'h0, 16'hFFFF});
        rd(rsl_pkg::OFS_STATE, 32'hFFFF_0001);
        rd(rsl_pkg::OFS_STATUS, 32'h0000_000D);
        frame(8'h01, 8'h05, 1'b1, 16'h0003, 2, 1'b0, st);
        chk({alert, relay_out}, {1'b0, 4'h3});
        wr(rsl_pkg::OFS_GAP, 16'h0000);
        cyc(100);
        chk(alert, 1'b0);
        wr(rsl_pkg::OFS_CTRL, 16'h0207);
        critical_in <= 1'b1;
        cyc(3);
        chk(ao_value, 16'h0100);
        critical_in <= 1'b0;
        cyc(3);
        chk(ao_value, ao_normal_value);
        wr(rsl_pkg::OFS_CTRL, 16'h0007);
        critical_in <= 1'b1;
        ao_normal_value <= 16'h4321;
        cyc(3);
        chk(ao_value, 16'h1234);
        wr(rsl_pkg::OFS_CTRL, 16'h0307);
        cyc(2);
        chk(ao_value, 16'h0000);
        critical_in <= 1'b0;
        cyc(3);
        chk(ao_value, 16'h4321);
    endtask : t_watch
    // At the fastest rate a bit is two cycles, so a character costs twenty.
    task automatic t_delay;
        for (int s = 0; s < 6; s++)
        begin
            wr(rsl_pkg::OFS_CTRL, 16'h0007 | 16'(s << 4));
            frame(8'h01, 8'h30, 1'b0, 16'h0000, 2 + rsl_pkg::REPLY_CHARS[s] * 20, 1'b0, st);
        end
        wr(rsl_pkg::OFS_CTRL, 16'h0067);
        rd(rsl_pkg::OFS_CTRL, 32'h0000_0057);
    endtask : t_delay
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_rates();
        t_station();
        t_gate();
        t_watch();
        t_delay();
        end_of_test();
    end
endmodule : rsl_link_ctrl_test
